// ==== design/mcd_map.svh ====
`ifndef MCD_MAP_SVH
`define MCD_MAP_SVH

// ----------------------------------------
// Widths and depths
// ----------------------------------------
`define MCD_INST_W      20
`define MCD_ADDR_W      11
`define MCD_STACK_DEPTH 4
`define MCD_PTR_W       2

// ----------------------------------------
// Instruction field positions
// ----------------------------------------
`define MCD_B_ALU       0
`define MCD_B_CLS_LO    3
`define MCD_B_CLS_HI    4
`define MCD_B_CTL       5
`define MCD_B_GATE      15
`define MCD_B_STORE     19
`define MCD_F_FUNC_HI   4
`define MCD_F_FUNC_LO   1
`define MCD_F_COND_HI   8
`define MCD_F_COND_LO   5
`define MCD_F_DEST_HI   8
`define MCD_F_DEST_LO   6
`define MCD_F_GRP_HI    14
`define MCD_F_GRP_LO    12
`define MCD_F_SUB_HI    18
`define MCD_F_SUB_LO    16
`define MCD_F_IMM_HI    16
`define MCD_F_IMM_LO    9
`define MCD_F_DIR_HI    19
`define MCD_F_DIR_LO    9

// ----------------------------------------
// Codes and reset values
// ----------------------------------------
`define MCD_GRP_PULSE   3'h1
`define MCD_GRP_MODE    3'h7
`define MCD_DEST_IMAGE  3'h4
`define MCD_DEST_SEQ    3'h5
`define MCD_FUNC_INCR   4'h2
`define MCD_ALL_OFF_N   8'hFF
`define MCD_ONE_HOT     8'h01
`define MCD_MODE_RESET  8'h00
`define MCD_BAND_MAX    8'hCF
`define MCD_LOOKUP_HIGH 3'h7
`define MCD_START_ADDR  11'h000
`define MCD_PTR_RESET   2'h3

`endif

// ==== design/mcd_pkg.sv ====
package mcd_pkg;

  // ----------------------------------------
  // Clock phases and sequencer functions
  // ----------------------------------------
  typedef enum logic [1:0] {
    MCD_PH0 = 2'b00,
    MCD_PH1 = 2'b01,
    MCD_PH2 = 2'b10
  } mcd_phase_e;

  typedef enum logic [1:0] {
    MCD_SEQ_INCR    = 2'b00,
    MCD_SEQ_JMP_REG = 2'b01,
    MCD_SEQ_RETURN  = 2'b10,
    MCD_SEQ_JMP_DIR = 2'b11
  } mcd_seq_e;

  typedef struct packed {
    mcd_seq_e sel;
    logic     fileEnN;
    logic     push;
  } mcd_func_s;

  // Group 1 pulse outputs, code 7 down to code 0
  typedef struct packed {
    logic oddHammerLoadN;
    logic oddShiftLoadN;
    logic evenHammerLoadN;
    logic evenShiftLoadN;
    logic bandTimeoutClearN;
    logic ramAddrDownPulseN;
    logic ramAddrUpPulseN;
    logic writeSentinelPulseN;
  } mcd_pulse_s;

  // Group 7 mode latches, entry 7 down to entry 0
  typedef struct packed {
    logic imageAddrBit1;
    logic imageAddrBit0;
    logic demandIncrDisable;
    logic bandDriveEnable;
    logic sentinelBitN;
    logic formatMode;
    logic imageAddrSourceSel;
    logic ramOutEnable;
  } mcd_mode_s;

endpackage : mcd_pkg

// ==== design/mcd_pin_sync.sv ====
module mcd_pin_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk_sys,
  input  wire logic rstN,
  input  wire logic pinIn,
  output logic      level
);

  logic stage1_q;
  logic stage2_q;
  logic stage3_q;

  // ----------------------------------------
  // Three-stage capture, change on agreement
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      stage1_q <= RESET_VAL;
      stage2_q <= RESET_VAL;
      stage3_q <= RESET_VAL;
      level    <= RESET_VAL;
    end else begin
      stage1_q <= pinIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      if (stage2_q == stage3_q) begin
        level <= stage3_q;
      end
    end
  end

endmodule : mcd_pin_sync

// ==== design/mcd_return_stack.sv ====
`include "mcd_map.svh"

module mcd_return_stack (
  input  wire logic                   clk_sys,
  input  wire logic                   rstN,
  input  wire logic                   push,
  input  wire logic                   pop,
  input  wire logic [`MCD_ADDR_W-1:0] pushData,
  output logic      [`MCD_ADDR_W-1:0] top
);

  logic [`MCD_ADDR_W-1:0] entry_q [0:`MCD_STACK_DEPTH-1];
  logic [`MCD_PTR_W-1:0]  ptr_q;
  wire  [`MCD_PTR_W-1:0]  ptrUp = ptr_q + 2'h1;

  // ----------------------------------------
  // Pointer on last written entry
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      ptr_q <= `MCD_PTR_RESET;
    end else if (push) begin
      ptr_q <= ptrUp;
    end else if (pop) begin
      ptr_q <= ptr_q - 2'h1;
    end
  end

  // Entry storage, oldest overwritten past four
  always_ff @(posedge clk_sys) begin
    if (push) begin
      entry_q[ptrUp] <= pushData;
    end
  end

  assign top = entry_q[ptr_q];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_idle2;
    (!push && !pop) [*2];
  endsequence

  sequence s_push_push_pop;
    push ##1 s_idle2 ##1 push ##1 s_idle2 ##1 pop;
  endsequence

  a_stack_top: assert property (@(posedge clk_sys) disable iff (!rstN)
    push |=> top == $past(pushData))
    else $error("stack top is not the last pushed address");

  a_stack_lifo: assert property (@(posedge clk_sys) disable iff (!rstN)
    s_push_push_pop |=> top == $past(pushData, 7))
    else $error("stack pop did not expose the earlier entry");

endmodule : mcd_return_stack

// ==== design/mcd_top.sv ====
// Operation
// - Return stack holds four addresses, leaving in reverse order of entry.
// - Stack pointer marks last written entry; returns read that entry.
// - Condition true branches, false increments; subroutine jump (push) or return uses stack.
// - Control-enable keeps advance select high and the sequencer increments.
// - Bits 0C-0E decode into eight active-low group enables, one at once.
// - Group decoder needs bit 05, class bits 03/04/00, and NOR(0F, not phase one).
// - Group 1 makes timing pulses, group 7 holds set/reset levels.
// - Group 1 acts with its enable low and bit 13 low.
// - Codes 0-3: write sentinel, RAM address up, down, band timeout clear.
// - Codes 4-7 load even/odd shift and hammer; bit 13 set does nothing.
// - Group 7 latch: bits 10-12 pick entry, bit 13 gives value.
// - Entries: RAM enable, load mode, format, sentinel, band drive, demand, image bits.
// - Move-immediate copies a constant into destination chosen by bits 06-08.
// - Sequence address takes bits 09-13; other destinations take eight bits from 09.
// - Move-immediate sequencer function comes from bits 01-04, coded increment.
// - Three band-image memories; exactly one selected after band identification.
// - Input bus shows image data on select 0, band position on 1.
// - Band position counter of cascaded 4-bit stages advances per hammer pulse reset.
// - Band position counter clears on index rising; range at most 207.
// - Image address from register, or register bus 0-4 with top bits high.
// - Load mode 0 picks image address register, 1 the lookup address.
// - Image address register loads from output bus on its load strobe.
// - Demand strobe rising edge steps RAM address when demand disable is low.
`include "mcd_map.svh"

module mcd_top (
  input  wire logic                   clk_sys,
  input  wire logic                   resetn,
  input  wire logic [`MCD_INST_W-1:0] instWord,
  input  wire logic                   conditionIn,
  input  wire logic                   hammerPulseResetN,
  input  wire logic                   bandIndex,
  input  wire logic                   demandStrobeN,
  input  wire logic [7:0]             aluOutputBus,
  input  wire logic                   imageAddrLoadN,
  input  wire logic [4:0]             registerBusLow,
  input  wire logic                   bandImageSelectN,
  input  wire logic                   bandCountSelectN,
  input  wire logic [7:0]             imageMemData,
  input  wire logic [1:0]             bandImageSel,
  output logic      [`MCD_ADDR_W-1:0] microAddr,
  output logic                        advancePcN,
  output logic      [7:0]             controlGroupEnableN,
  output mcd_pkg::mcd_pulse_s         groupOnePulses,
  output mcd_pkg::mcd_mode_s          modeLatch,
  output logic                        bandDriveEnableN,
  output logic                        ramAddrIncrN,
  output logic      [7:0]             mviData,
  output logic      [7:0]             mviLoadN,
  output logic      [7:0]             imageMemAddr,
  output logic      [2:0]             imageMemSelectN,
  output logic      [7:0]             inputBus,
  output logic                        inputBusOe,
  output logic                        inbusMuxEnableN,
  output logic      [8:0]             bandPositionValue
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rstMeta_q;
  logic rstN;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rstMeta_q <= 1'b0;
      rstN      <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstN      <= rstMeta_q;
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic hammerLevel;
  logic indexLevel;
  logic demandLevel;

  mcd_pin_sync #(.RESET_VAL(1'b1)) u_syncHammer (
    .clk_sys (clk_sys),
    .rstN    (rstN),
    .pinIn   (hammerPulseResetN),
    .level   (hammerLevel)
  );

  mcd_pin_sync #(.RESET_VAL(1'b0)) u_syncIndex (
    .clk_sys (clk_sys),
    .rstN    (rstN),
    .pinIn   (bandIndex),
    .level   (indexLevel)
  );

  mcd_pin_sync #(.RESET_VAL(1'b1)) u_syncDemand (
    .clk_sys (clk_sys),
    .rstN    (rstN),
    .pinIn   (demandStrobeN),
    .level   (demandLevel)
  );

  // ----------------------------------------
  // Three-phase cycle
  // ----------------------------------------
  mcd_pkg::mcd_phase_e phase_q;
  mcd_pkg::mcd_phase_e phase_d;

  always_comb begin
    unique case (phase_q)
      mcd_pkg::MCD_PH0: phase_d = mcd_pkg::MCD_PH1;
      mcd_pkg::MCD_PH1: phase_d = mcd_pkg::MCD_PH2;
      mcd_pkg::MCD_PH2: phase_d = mcd_pkg::MCD_PH0;
      default:          phase_d = mcd_pkg::MCD_PH0;
    endcase
  end

  wire phaseOne = phase_q == mcd_pkg::MCD_PH1;
  wire phaseTwo = phase_q == mcd_pkg::MCD_PH2;

  // ----------------------------------------
  // Instruction class decode
  // ----------------------------------------
  wire nonAlu    = ~instWord[`MCD_B_ALU];
  wire classZero = nonAlu & ~instWord[`MCD_B_CLS_LO] & ~instWord[`MCD_B_CLS_HI];
  wire ctlEnable = classZero & instWord[`MCD_B_CTL];
  wire moveImmediate = classZero & ~instWord[`MCD_B_CTL];
  wire condInstr = nonAlu & (instWord[`MCD_B_CLS_LO] | instWord[`MCD_B_CLS_HI]);
  wire condHolds = (instWord[`MCD_F_COND_HI:`MCD_F_COND_LO] == 4'h0) | conditionIn;

  // Advance select: low forces increment
  wire advPcN = nonAlu & (~condInstr | condHolds);
  wire [3:0] funcBits = (advPcN & ~ctlEnable) ?
                        instWord[`MCD_F_FUNC_HI:`MCD_F_FUNC_LO] :
                        `MCD_FUNC_INCR;
  wire mcd_pkg::mcd_func_s seqFunc = mcd_pkg::mcd_func_s'(funcBits);

  // ----------------------------------------
  // Microsequencer next address
  // ----------------------------------------
  logic [`MCD_ADDR_W-1:0] microAddr_q;
  logic [`MCD_ADDR_W-1:0] seqAddr_q;
  logic [`MCD_ADDR_W-1:0] stackTop;

  wire [`MCD_ADDR_W-1:0] pcInc = microAddr_q + 11'h001;
  wire [`MCD_ADDR_W-1:0] directAddr = instWord[`MCD_F_DIR_HI:`MCD_F_DIR_LO];
  wire stackPush = phaseTwo & ~seqFunc.fileEnN & seqFunc.push;
  wire stackPop  = phaseTwo & ~seqFunc.fileEnN & ~seqFunc.push;
  wire [`MCD_ADDR_W-1:0] microAddr_d =
      (seqFunc.sel == mcd_pkg::MCD_SEQ_INCR)    ? pcInc :
      (seqFunc.sel == mcd_pkg::MCD_SEQ_JMP_REG) ? seqAddr_q :
      (seqFunc.sel == mcd_pkg::MCD_SEQ_RETURN)  ? stackTop :
      directAddr;

  mcd_return_stack u_stack (
    .clk_sys  (clk_sys),
    .rstN     (rstN),
    .push     (stackPush),
    .pop      (stackPop),
    .pushData (pcInc),
    .top      (stackTop)
  );

  // ----------------------------------------
  // Control group decode
  // ----------------------------------------
  wire groupDecEn = ctlEnable & ~(instWord[`MCD_B_GATE] | ~phaseOne);
  wire [2:0] groupSel = instWord[`MCD_F_GRP_HI:`MCD_F_GRP_LO];
  wire [2:0] subSel = instWord[`MCD_F_SUB_HI:`MCD_F_SUB_LO];
  wire storeBit = instWord[`MCD_B_STORE];
  wire [7:0] groupDecN = groupDecEn ? ~(`MCD_ONE_HOT << groupSel) : `MCD_ALL_OFF_N;
  wire g1Act = ~groupDecN[`MCD_GRP_PULSE] & ~storeBit;
  wire [7:0] g1DecN = g1Act ? ~(`MCD_ONE_HOT << subSel) : `MCD_ALL_OFF_N;
  wire g7Write = ~groupDecN[`MCD_GRP_MODE];
  wire driveWrite = g7Write & (subSel == 3'h4);

  // ----------------------------------------
  // Move-immediate decode
  // ----------------------------------------
  wire [2:0] mviDest = instWord[`MCD_F_DEST_HI:`MCD_F_DEST_LO];
  wire [7:0] immByte = instWord[`MCD_F_IMM_HI:`MCD_F_IMM_LO];
  wire mviStrobe = moveImmediate & phaseOne;
  wire [7:0] mviLoadN_d = mviStrobe ? ~(`MCD_ONE_HOT << mviDest) : `MCD_ALL_OFF_N;
  wire loadSeq = mviStrobe & (mviDest == `MCD_DEST_SEQ);
  wire loadImageImm = mviStrobe & (mviDest == `MCD_DEST_IMAGE);

  // ----------------------------------------
  // Image addressing and memory select
  // ----------------------------------------
  logic [7:0] imageAddr_q;
  logic [7:0] modeBits_q;

  wire [7:0] imageMemAddr_d = modeBits_q[1] ?
                              {`MCD_LOOKUP_HIGH, registerBusLow} :
                              imageAddr_q;
  wire [2:0] imageMemSelectN_d = (bandImageSel == 2'h0) ? 3'b110 :
                                 (bandImageSel == 2'h1) ? 3'b101 : 3'b011;

  // ----------------------------------------
  // Band position and strobe edges
  // ----------------------------------------
  logic [3:0] bandLo_q;
  logic [3:0] bandHi_q;
  logic       hammerPrev_q;
  logic       indexPrev_q;
  logic       demandPrev_q;

  wire hammerRise = hammerLevel & ~hammerPrev_q;
  wire indexRise  = indexLevel & ~indexPrev_q;
  wire demandRise = demandLevel & ~demandPrev_q;
  wire bandAdvance = hammerRise & ({bandHi_q, bandLo_q} < `MCD_BAND_MAX);
  wire bandCarry = bandLo_q == 4'hF;
  wire ramIncr_d = ~((demandRise & ~modeBits_q[5]) | ~g1DecN[1]);

  // ----------------------------------------
  // Input bus multiplexer
  // ----------------------------------------
  wire muxOffN = bandImageSelectN & bandCountSelectN;
  wire [7:0] inputBus_d = bandImageSelectN ? {bandHi_q, bandLo_q} : imageMemData;

  // ----------------------------------------
  // Sequencer and phase registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      phase_q     <= mcd_pkg::MCD_PH0;
      microAddr_q <= `MCD_START_ADDR;
      seqAddr_q   <= `MCD_START_ADDR;
      advancePcN  <= 1'b0;
    end else begin
      phase_q    <= phase_d;
      advancePcN <= advPcN;
      if (phaseTwo) begin
        microAddr_q <= microAddr_d;
      end
      if (loadSeq) begin
        seqAddr_q <= directAddr;
      end
    end
  end

  assign microAddr = microAddr_q;

  // Control group outputs and mode latch
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      controlGroupEnableN <= `MCD_ALL_OFF_N;
      groupOnePulses      <= mcd_pkg::mcd_pulse_s'(`MCD_ALL_OFF_N);
      modeBits_q          <= `MCD_MODE_RESET;
      bandDriveEnableN    <= 1'b1;
    end else begin
      controlGroupEnableN <= groupDecN;
      groupOnePulses      <= mcd_pkg::mcd_pulse_s'(g1DecN);
      if (g7Write) begin
        modeBits_q[subSel] <= storeBit;
      end
      if (driveWrite) begin
        bandDriveEnableN <= ~storeBit;
      end
    end
  end

  assign modeLatch        = mcd_pkg::mcd_mode_s'(modeBits_q);

  // Move-immediate and image address registers
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      mviLoadN        <= `MCD_ALL_OFF_N;
      mviData         <= 8'h00;
      imageAddr_q     <= 8'h00;
      imageMemAddr    <= 8'h00;
      imageMemSelectN <= 3'b110;
    end else begin
      mviLoadN        <= mviLoadN_d;
      mviData         <= immByte;
      imageMemAddr    <= imageMemAddr_d;
      imageMemSelectN <= imageMemSelectN_d;
      if (loadImageImm) begin
        imageAddr_q <= immByte;
      end else if (!imageAddrLoadN) begin
        imageAddr_q <= aluOutputBus;
      end
    end
  end

  // Band counter, edges and input bus
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      bandLo_q        <= 4'h0;
      bandHi_q        <= 4'h0;
      hammerPrev_q    <= 1'b1;
      indexPrev_q     <= 1'b0;
      demandPrev_q    <= 1'b1;
      ramAddrIncrN    <= 1'b1;
      inputBus        <= 8'h00;
      inputBusOe      <= 1'b0;
      inbusMuxEnableN <= 1'b1;
    end else begin
      hammerPrev_q    <= hammerLevel;
      indexPrev_q     <= indexLevel;
      demandPrev_q    <= demandLevel;
      ramAddrIncrN    <= ramIncr_d;
      inputBus        <= inputBus_d;
      inputBusOe      <= ~muxOffN;
      inbusMuxEnableN <= muxOffN;
      if (indexRise) begin
        bandLo_q <= 4'h0;
        bandHi_q <= 4'h0;
      end else if (bandAdvance) begin
        bandLo_q <= bandLo_q + 4'h1;
        if (bandCarry) begin
          bandHi_q <= bandHi_q + 4'h1;
        end
      end
    end
  end

  assign bandPositionValue = {1'b0, bandHi_q, bandLo_q};

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstN);

  a_group_onehot: assert property ($countones(~controlGroupEnableN) <= 1)
    else $error("more than one group enable active");

  a_group_cause: assert property (
    groupDecEn |=> controlGroupEnableN == ~(`MCD_ONE_HOT << $past(groupSel)))
    else $error("group enable does not follow the select bits");

  a_group_idle: assert property (!groupDecEn |=> controlGroupEnableN == 8'hFF)
    else $error("group enable without its gating terms");

  a_pulse_code: assert property (
    (groupDecEn && groupSel == 3'h1 && !storeBit) |=>
    groupOnePulses == ~(`MCD_ONE_HOT << $past(subSel)) ##1 groupOnePulses == 8'hFF)
    else $error("group one pulse wrong or longer than one cycle");

  a_pulse_quiet: assert property ((!groupDecEn || storeBit) |=> groupOnePulses == 8'hFF)
    else $error("group one pulse with bit 13 set");

  a_mode_write: assert property (
    (groupDecEn && groupSel == 3'h7) |=> modeBits_q[$past(subSel)] == $past(storeBit))
    else $error("mode latch entry not written");

  a_ctl_incr: assert property (
    (ctlEnable && phaseTwo) |=> advancePcN && microAddr == $past(microAddr) + 11'h001)
    else $error("control-enable did not increment");

  a_cond_fail: assert property (
    (condInstr && !condHolds && phaseTwo) |=> microAddr == $past(microAddr) + 11'h001)
    else $error("failed condition did not increment");

  a_cond_take: assert property (
    (condInstr && condHolds && phaseTwo && seqFunc.sel == mcd_pkg::MCD_SEQ_JMP_DIR)
    |=> microAddr == $past(directAddr))
    else $error("held condition did not branch");

  a_band_clear: assert property (indexRise |=> bandPositionValue == 9'h000)
    else $error("band counter not cleared by index");

  a_band_max: assert property (bandPositionValue <= 9'h0CF)
    else $error("band counter past its range");

  a_mux_image: assert property (!bandImageSelectN |=> inputBus == $past(imageMemData))
    else $error("input bus not showing image data");

  a_lookup_addr: assert property (
    modeBits_q[1] |=> imageMemAddr == {3'h7, $past(registerBusLow)})
    else $error("lookup address wrong");

endmodule : mcd_top

// ==== tb/mcd_far_end.sv ====
// Timing board lines seen by the decoder: hammer, index, demand
module mcd_far_end (
  input  wire logic clk_sys,
  output logic      hammerPulseResetN,
  output logic      bandIndex,
  output logic      demandStrobeN
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle levels of the three lines
  initial begin
    hammerPulseResetN = 1'b1;
    bandIndex         = 1'b0;
    demandStrobeN     = 1'b1;
  end

  // One line pulsed n times, 4 cycles active, 5 idle before the next
  task automatic pulse(input int sel, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      case (sel)
        0:       hammerPulseResetN = 1'b0;
        1:       bandIndex = 1'b1;
        default: demandStrobeN = 1'b0;
      endcase
      repeat (4) @(posedge clk_sys);
      #1 {hammerPulseResetN, bandIndex, demandStrobeN} = 3'h5;
      repeat (4) @(posedge clk_sys);
    end
  endtask : pulse
endmodule : mcd_far_end

// ==== tb/mcd_top_tb.sv ====
`define CHK(a, e, m) begin compares++; if ((a) !== (e)) begin failCount++; $display("wrong value at %0t: %s", $time, m); end end

module mcd_top_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_sys, resetn, conditionIn, imageAddrLoadN, bandImageSelectN, bandCountSelectN;
  logic hammerPulseResetN, bandIndex, demandStrobeN, advancePcN, bandDriveEnableN;
  logic ramAddrIncrN, inputBusOe, inbusMuxEnableN, adv;
  logic [19:0] instWord;
  logic [7:0]  aluOutputBus, imageMemData, controlGroupEnableN, mviData, mviLoadN;
  logic [7:0]  imageMemAddr, inputBus, grpN, pul, ldN, dat, expMode;
  logic [4:0]  registerBusLow;
  logic [1:0]  bandImageSel;
  logic [10:0] microAddr, pc, base;
  logic [2:0]  imageMemSelectN;
  logic [8:0]  bandPositionValue;
  logic [2:0]  selExp [4] = '{3'h6, 3'h5, 3'h3, 3'h3};
  mcd_pkg::mcd_pulse_s groupOnePulses;
  mcd_pkg::mcd_mode_s  modeLatch;
  int failCount, compares, incCnt;

  mcd_top dut_u (.clk_sys, .resetn, .instWord, .conditionIn, .hammerPulseResetN, .bandIndex,
    .demandStrobeN, .aluOutputBus, .imageAddrLoadN, .registerBusLow, .bandImageSelectN,
    .bandCountSelectN, .imageMemData, .bandImageSel, .microAddr, .advancePcN,
    .controlGroupEnableN, .groupOnePulses, .modeLatch, .bandDriveEnableN, .ramAddrIncrN,
    .mviData, .mviLoadN, .imageMemAddr, .imageMemSelectN, .inputBus, .inputBusOe,
    .inbusMuxEnableN, .bandPositionValue);
  mcd_far_end far_u (.clk_sys, .hammerPulseResetN, .bandIndex, .demandStrobeN);

  // Clock and RAM step counter
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (ramAddrIncrN === 1'b0) incCnt <= incCnt + 1;

  function automatic logic [19:0] ctl(input int g, input int s, input int v);
    return 20'(32'h20 | g << 12 | s << 16 | v << 19);
  endfunction : ctl
  function automatic logic [19:0] br(input int f, input int c, input int t);
    return 20'(f << 1 | c << 5 | t << 9);
  endfunction : br
  function automatic logic [19:0] move_immediate(input int d, input int i);
    return 20'(4 | d << 6 | i << 9);
  endfunction : move_immediate

  // One instruction over three phases, strobes caught mid-way
  task automatic run(input logic [19:0] iw, input logic [10:0] nxt);
    instWord = iw;
    repeat (2) @(posedge clk_sys);
    #1 {grpN, pul, ldN, dat, adv} = {controlGroupEnableN, groupOnePulses, mviLoadN, mviData,
      advancePcN};
    @(posedge clk_sys);
    #1;
    `CHK(microAddr, nxt, "next address")
    pc = nxt;
  endtask : run

  // Far end pulses while harmless instructions keep running
  task automatic farRun(input int sel, input int n);
    fork
      far_u.pulse(sel, n);
      repeat (n * 3 + 5) run(ctl(7, 0, 0), pc + 1);
    join
  endtask : farRun

  task automatic testDone();
    $display("compares %0d mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : testDone

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    failCount++;
    testDone();
  end

  // Main sequence
  initial begin
    {resetn, conditionIn, aluOutputBus, imageMemData, registerBusLow, bandImageSel} = '0;
    {imageAddrLoadN, bandImageSelectN, bandCountSelectN} = 3'h7;
    instWord = 20'h00001;
    expMode  = 8'h00;
    repeat (6) @(posedge clk_sys);
    #1;
    `CHK(modeLatch, 8'h00, "mode reset")
    `CHK(bandPositionValue, 9'h000, "count reset")
    `CHK(controlGroupEnableN, 8'hFF, "idle enables")
    resetn = 1'b1;
    repeat (5) @(posedge clk_sys);
    #1 run(br(14, 0, 16), 11'h010);
    for (int g = 0; g < 8; g++) begin
      run(ctl(g, 0, 0), pc + 1);
      `CHK(grpN, ~(8'h01 << g), "group enable")
      `CHK(adv, 1'b1, "advance select")
    end
    run(ctl(7, 0, 1) | 20'h08000, pc + 1);
    `CHK(grpN, 8'hFF, "gated enable")
    run(ctl(1, 0, 0) | 20'h00001, pc + 1);
    `CHK(grpN, 8'hFF, "alu enable")
    for (int c = 0; c < 8; c++) begin
      run(ctl(1, c, 0), pc + 1);
      `CHK(pul, ~(8'h01 << c), "pulse code")
    end
    run(ctl(1, 5, 1), pc + 1);
    `CHK(pul, 8'hFF, "silent code")
    for (int k = 0; k < 16; k++) begin
      run(ctl(7, k % 8, k < 8), pc + 1);
      expMode[k % 8] = (k < 8);
      `CHK(modeLatch, expMode, "mode latch")
      if (k == 7) `CHK(bandDriveEnableN, 1'b0, "band drive")
    end
    aluOutputBus   = 8'hBF;
    imageAddrLoadN = 1'b0;
    run(ctl(7, 0, 0), pc + 1);
    imageAddrLoadN = 1'b1;
    `CHK(imageMemAddr, 8'hBF, "image register")
    registerBusLow = 5'h15;
    run(ctl(7, 1, 1), pc + 1);
    `CHK(imageMemAddr, 8'hF5, "lookup address")
    run(ctl(7, 1, 0), pc + 1);
    `CHK(imageMemAddr, 8'hBF, "register address")
    run(move_immediate(4, 58), pc + 1);
    `CHK(ldN, 8'hEF, "image strobe")
    `CHK(dat, 8'h3A, "constant")
    `CHK(imageMemAddr, 8'h3A, "loaded image")
    run(move_immediate(5, 11'h5A3), pc + 1);
    `CHK(ldN, 8'hDF, "sequence strobe")
    run(br(6, 0, 0), 11'h5A3);
    base = pc;
    for (int k = 1; k < 5; k++) run(br(13, 0, k << 8), 11'(k << 8));
    for (int k = 3; k >= 0; k--) run(br(8, 0, 0), (k > 0) ? 11'(k << 8 | 1) : base + 1);
    conditionIn = 1'b1;
    run(br(14, 1, 80), 11'h050);
    conditionIn = 1'b0;
    run(br(14, 1, 112), 11'h051);
    farRun(0, 5);
    `CHK(bandPositionValue, 9'h005, "band count")
    {bandImageSelectN, bandCountSelectN} = 2'h2;
    run(ctl(7, 0, 0), pc + 1);
    `CHK(inputBus, 8'h05, "count on bus")
    `CHK(inputBusOe, 1'b1, "bus driven")
    `CHK(inbusMuxEnableN, 1'b0, "mux enabled")
    imageMemData = 8'hC3;
    {bandImageSelectN, bandCountSelectN} = 2'h1;
    run(ctl(7, 0, 0), pc + 1);
    `CHK(inputBus, 8'hC3, "image on bus")
    {bandImageSelectN, bandCountSelectN} = 2'h3;
    run(ctl(7, 0, 0), pc + 1);
    `CHK(inputBusOe, 1'b0, "bus off")
    `CHK(inbusMuxEnableN, 1'b1, "mux disabled")
    farRun(1, 1);
    `CHK(bandPositionValue, 9'h000, "index clear")
    farRun(0, 210);
    `CHK(bandPositionValue, 9'h0CF, "count ceiling")
    for (int b = 0; b < 4; b++) begin
      bandImageSel = 2'(b);
      run(ctl(7, 0, 0), pc + 1);
      `CHK(imageMemSelectN, selExp[b], "memory select")
    end
    incCnt = 0;
    farRun(2, 3);
    `CHK(incCnt, 3, "demand steps")
    run(ctl(7, 5, 1), pc + 1);
    incCnt = 0;
    farRun(2, 3);
    `CHK(incCnt, 0, "demand disabled")
    `CHK(ramAddrIncrN, 1'b1, "increment idle")
    testDone();
  end
endmodule : mcd_top_tb
